// file: design/capture_gate_top.sv
// Capture latches, capture pin routing and output pin gating of a two-channel timer.
// Assumes counter_value is the timer down-counter, synchronous to clk.
// Operation
// - Rising edge on a channel loads its 16-bit rising latch from the counter.
// - Falling edge on a channel loads its 16-bit falling latch from the counter.
// - Pin-connect bit 0 keeps that pin away from capture; no latching occurs.
// - Pin-connect bit 1 with timer function routes the pin in as input.
// - Pin-connect bit 0 selects port A pin twelve for capture channel 0.
// - Pin-connect bit 1 selects port A pin thirteen for capture channel 1.
// - Output 0 reaches its pin only while gate bit 0 is set.
// - Output 1 reaches its pin only while gate bit 1 is set.
// - An output reaches its pin only with gate bit set and timer function selected.
// - A rising latch load sets the rising-latched flag; writing zero clears it.
// - Latching and its interrupt happen only while the channel's capture bit is set.
// - An enabled latch event sets the capture interrupt flag; writing one clears it.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ns
module capture_gate_top
  import cap_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Register port
  input  wire bus_req_t    bus_req,
  output logic      [31:0] rd_data,
  // Timer core
  input  wire logic [15:0] counter_value,
  input  wire logic [1:0]  timer_out,
  // Capture pins
  input  wire logic        port_a_pin_twelve,
  input  wire logic        port_a_pin_thirteen,
  input  wire logic [1:0]  port_a_function_select,
  output logic      [1:0]  cap_pin_oe,
  output logic      [1:0]  cap_pin_routed,
  // Output pins
  input  wire logic [1:0]  out_function_select,
  output logic      [1:0]  out_pin_level,
  output logic      [1:0]  out_pin_oe,
  // Interrupt
  output logic             irq
);

  // ---------------- Registers ----------------
  logic [1:0][15:0] rise_val_q;
  logic [1:0][15:0] rise_val_d;
  logic [1:0][15:0] fall_val_q;
  logic [1:0][15:0] fall_val_d;
  logic [1:0]       capture_pin_connect_q;
  logic [1:0]       out_gate_q;
  logic [1:0]       capture_on_q;
  logic [1:0]       rise_ie_q;
  logic [1:0]       fall_ie_q;
  logic [1:0]       irq_flag_q;
  logic [1:0]       irq_flag_d;
  logic [1:0]       rise_flag_q;
  logic [1:0]       rise_flag_d;
  logic [1:0]       fall_flag_q;
  logic [1:0]       fall_flag_d;
  logic [3:0]       irq_status_q;
  logic [3:0]       irq_status_d;
  logic [3:0]       irq_mask_q;
  logic [31:0]      rd_data_q;

  // ---------------- Address decode ----------------
  wire hit_ctrl   = bus_req.addr == OFF_CAPTURE_CTRL;
  wire hit_rise0  = bus_req.addr == OFF_RISE_LATCH_0;
  wire hit_fall0  = bus_req.addr == OFF_FALL_LATCH_0;
  wire hit_rise1  = bus_req.addr == OFF_RISE_LATCH_1;
  wire hit_fall1  = bus_req.addr == OFF_FALL_LATCH_1;
  wire hit_pin    = bus_req.addr == OFF_CAPTURE_PIN;
  wire hit_gate   = bus_req.addr == OFF_OUTPUT_GATE;
  wire hit_status = bus_req.addr == OFF_IRQ_STATUS;
  wire hit_mask   = bus_req.addr == OFF_IRQ_MASK;

  wire wr_ctrl    = bus_req.wr & hit_ctrl;
  wire wr_pin     = bus_req.wr & hit_pin;
  wire wr_gate    = bus_req.wr & hit_gate;
  wire wr_mask    = bus_req.wr & hit_mask;
  wire rd_status  = bus_req.rd & hit_status;

  // ---------------- Capture pin routing ----------------
  // A pin counts as routed only while connected and switched to the timer function
  wire [1:0] route_on = capture_pin_connect_q & port_a_function_select;

  // Capture pins are inputs only; this block never drives them
  assign cap_pin_oe     = 2'h0;
  assign cap_pin_routed = route_on;

  // Channel sources are fixed by position in the connect field
  wire [1:0] cap_pin_level = {port_a_pin_thirteen, port_a_pin_twelve};

  edge_ev_t [1:0] edge_ev;
  logic     [1:0] ev_rise;
  logic     [1:0] ev_fall;
  logic     [1:0] ev_irq;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      cap_edge_detect u_edge (
        .clk       (clk),
        .rst_b     (rst_b),
        .pin_level (cap_pin_level[ch]),
        .route_on  (route_on[ch]),
        .edge_ev   (edge_ev[ch])
      );

      // Edges on a channel with capture switched off are dropped entirely
      assign ev_rise[ch] = edge_ev[ch].rise & capture_on_q[ch];
      assign ev_fall[ch] = edge_ev[ch].fall & capture_on_q[ch];
      assign ev_irq[ch]  = (ev_rise[ch] & rise_ie_q[ch])
                         | (ev_fall[ch] & fall_ie_q[ch]);

      // Latch loads
      assign rise_val_d[ch] = ev_rise[ch] ? counter_value : rise_val_q[ch];
      assign fall_val_d[ch] = ev_fall[ch] ? counter_value : fall_val_q[ch];

      // Flags: the hardware set wins over a clear in the same cycle
      wire clr_rise = wr_ctrl & ~bus_req.wdata[ctrl_pos(ch, POS_RISE_FLAG)];
      wire clr_fall = wr_ctrl & ~bus_req.wdata[ctrl_pos(ch, POS_FALL_FLAG)];
      wire clr_irq  = wr_ctrl & bus_req.wdata[ctrl_pos(ch, POS_IRQ_FLAG)];

      assign rise_flag_d[ch] = ev_rise[ch] | (rise_flag_q[ch] & ~clr_rise);
      assign fall_flag_d[ch] = ev_fall[ch] | (fall_flag_q[ch] & ~clr_fall);
      assign irq_flag_d[ch]  = ev_irq[ch] | (irq_flag_q[ch] & ~clr_irq);

      // Sticky status: events of this channel
      assign irq_status_d[2*ch+POS_EV_RISE] = ev_rise[ch]
        | (irq_status_q[2*ch+POS_EV_RISE] & ~rd_status);
      assign irq_status_d[2*ch+POS_EV_FALL] = ev_fall[ch]
        | (irq_status_q[2*ch+POS_EV_FALL] & ~rd_status);
    end
  endgenerate

  // ---------------- Latches and flags ----------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rise_val_q  <= {2{LATCH_RST}};
      fall_val_q  <= {2{LATCH_RST}};
      rise_flag_q <= CTRL_BITS_RST;
      fall_flag_q <= CTRL_BITS_RST;
      irq_flag_q  <= CTRL_BITS_RST;
    end else begin
      rise_val_q  <= rise_val_d;
      fall_val_q  <= fall_val_d;
      rise_flag_q <= rise_flag_d;
      fall_flag_q <= fall_flag_d;
      irq_flag_q  <= irq_flag_d;
    end
  end

  // ---------------- Control write fields ----------------
  wire [1:0] ctrl_capture_on = {bus_req.wdata[ctrl_pos(1, POS_CAPTURE_ON)],
                                bus_req.wdata[ctrl_pos(0, POS_CAPTURE_ON)]};
  wire [1:0] ctrl_rise_ie    = {bus_req.wdata[ctrl_pos(1, POS_RISE_IE)],
                                bus_req.wdata[ctrl_pos(0, POS_RISE_IE)]};
  wire [1:0] ctrl_fall_ie    = {bus_req.wdata[ctrl_pos(1, POS_FALL_IE)],
                                bus_req.wdata[ctrl_pos(0, POS_FALL_IE)]};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      capture_on_q <= CTRL_BITS_RST;
      rise_ie_q    <= CTRL_BITS_RST;
      fall_ie_q    <= CTRL_BITS_RST;
    end else if (wr_ctrl) begin
      capture_on_q <= ctrl_capture_on;
      rise_ie_q    <= ctrl_rise_ie;
      fall_ie_q    <= ctrl_fall_ie;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      capture_pin_connect_q <= CAPTURE_PIN_RST;
    end else if (wr_pin) begin
      capture_pin_connect_q <= bus_req.wdata[1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_gate_q <= OUTPUT_GATE_RST;
    end else if (wr_gate) begin
      out_gate_q <= bus_req.wdata[1:0];
    end
  end

  // ---------------- Interrupt ----------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_mask_q   <= IRQ_MASK_RST;
      irq_status_q <= IRQ_STATUS_RST;
    end else begin
      irq_status_q <= irq_status_d;
      if (wr_mask) begin
        irq_mask_q <= bus_req.wdata[3:0];
      end
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

  // ---------------- Output pin gating ----------------
  // Combinational on purpose: a registered gate would delay every timer edge a cycle
  out_pin_gate u_gate (
    .timer_out (timer_out),
    .gate_en   (out_gate_q),
    .func_sel  (out_function_select),
    .pin_level (out_pin_level),
    .pin_oe    (out_pin_oe)
  );

  // ---------------- Read path ----------------
  logic [31:0] ctrl_view;

  always_comb begin
    ctrl_view = RD_ZERO;
    for (int c = 0; c < 2; c++) begin
      ctrl_view[ctrl_pos(c, POS_RISE_IE)]    = rise_ie_q[c];
      ctrl_view[ctrl_pos(c, POS_FALL_IE)]    = fall_ie_q[c];
      ctrl_view[ctrl_pos(c, POS_CAPTURE_ON)] = capture_on_q[c];
      ctrl_view[ctrl_pos(c, POS_IRQ_FLAG)]   = irq_flag_q[c];
      ctrl_view[ctrl_pos(c, POS_RISE_FLAG)]  = rise_flag_q[c];
      ctrl_view[ctrl_pos(c, POS_FALL_FLAG)]  = fall_flag_q[c];
    end
  end

  // Unmapped addresses read as zero
  wire [31:0] rd_mux =
      hit_ctrl   ? ctrl_view :
      hit_rise0  ? {16'h0000, rise_val_q[0]} :
      hit_fall0  ? {16'h0000, fall_val_q[0]} :
      hit_rise1  ? {16'h0000, rise_val_q[1]} :
      hit_fall1  ? {16'h0000, fall_val_q[1]} :
      hit_pin    ? {30'h0000_0000, capture_pin_connect_q} :
      hit_gate   ? {30'h0000_0000, out_gate_q} :
      hit_status ? {28'h000_0000, irq_status_q} :
      hit_mask   ? {28'h000_0000, irq_mask_q} :
      RD_ZERO;

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_q <= RD_ZERO;
    end else begin
      rd_data_q <= bus_req.rd ? rd_mux : RD_ZERO;
    end
  end

  assign rd_data = rd_data_q;

endmodule

// file: design/cap_pkg.sv
// Constants, field layouts and carrier types for the capture latch and pin gate.
// Assumes a 32-bit register port with byte addresses in the low eight bits.
package cap_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CAPTURE_CTRL  = 8'h50;
  localparam logic [7:0] OFF_RISE_LATCH_0  = 8'h58;
  localparam logic [7:0] OFF_FALL_LATCH_0  = 8'h5C;
  localparam logic [7:0] OFF_RISE_LATCH_1  = 8'h60;
  localparam logic [7:0] OFF_FALL_LATCH_1  = 8'h64;
  localparam logic [7:0] OFF_CAPTURE_PIN   = 8'h78;
  localparam logic [7:0] OFF_OUTPUT_GATE   = 8'h7C;
  localparam logic [7:0] OFF_IRQ_STATUS    = 8'h80;
  localparam logic [7:0] OFF_IRQ_MASK      = 8'h84;

  // Capture control field positions, channel 0; channel 1 sits one stride higher
  localparam int unsigned CH_STRIDE        = 16;
  localparam int unsigned POS_RISE_IE      = 1;
  localparam int unsigned POS_FALL_IE      = 2;
  localparam int unsigned POS_CAPTURE_ON   = 3;
  localparam int unsigned POS_IRQ_FLAG     = 4;
  localparam int unsigned POS_RISE_FLAG    = 6;
  localparam int unsigned POS_FALL_FLAG    = 7;

  // Interrupt status layout: rising event at 2*ch, falling event at 2*ch+1
  localparam int unsigned POS_EV_RISE      = 0;
  localparam int unsigned POS_EV_FALL      = 1;

  // Reset values
  localparam logic [15:0] LATCH_RST        = 16'h0000;
  localparam logic [1:0]  CAPTURE_PIN_RST  = 2'h0;
  localparam logic [1:0]  OUTPUT_GATE_RST  = 2'h0;
  localparam logic [1:0]  CTRL_BITS_RST    = 2'h0;
  localparam logic [3:0]  IRQ_MASK_RST     = 4'h0;
  localparam logic [3:0]  IRQ_STATUS_RST   = 4'h0;
  localparam logic [31:0] RD_ZERO          = 32'h0000_0000;

  // Register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  // Edge report of one capture channel
  typedef struct packed {
    logic rise;
    logic fall;
  } edge_ev_t;

  // Bit index of a capture control field for a channel
  function automatic int unsigned ctrl_pos(input int unsigned ch, input int unsigned field);
    ctrl_pos = ch * CH_STRIDE + field;
  endfunction

endpackage

// file: design/cap_edge_detect.sv
// Synchroniser and edge detector for one capture input pin.
// Assumes the pin is asynchronous to clk; edges come out one to two cycles late.
`timescale 1ns/1ns
module cap_edge_detect
  import cap_pkg::*;
(
  // Clock and reset
  input  wire logic     clk,
  input  wire logic     rst_b,
  // Pin and routing
  input  wire logic     pin_level,
  input  wire logic     route_on,
  // Edge report
  output edge_ev_t      edge_ev
);

  logic sync1_q;
  logic sync2_q;
  logic last_q;
  logic route_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      last_q  <= 1'b0;
      route_q <= 1'b0;
    end else begin
      sync1_q <= pin_level;
      sync2_q <= sync1_q;
      last_q  <= sync2_q;
      route_q <= route_on;
    end
  end

  // The history keeps tracking while unrouted, so connecting never fakes an edge
  wire routed_both = route_on & route_q;

  assign edge_ev.rise = routed_both & sync2_q & ~last_q;
  assign edge_ev.fall = routed_both & ~sync2_q & last_q;

endmodule

// file: design/out_pin_gate.sv
// Gates the two timer outputs onto their pins.
// Assumes the pad drives the pin only while its output enable is high.
`timescale 1ns/1ns
module out_pin_gate
  import cap_pkg::*;
(
  // Timer outputs and controls
  input  wire logic [1:0] timer_out,
  input  wire logic [1:0] gate_en,
  input  wire logic [1:0] func_sel,
  // Pins
  output logic      [1:0] pin_level,
  output logic      [1:0] pin_oe
);

  // Both the gate bit and the pin's function selection must agree
  wire [1:0] drive_on = gate_en & func_sel;

  assign pin_oe    = drive_on;
  assign pin_level = timer_out & drive_on;

endmodule

// file: tb/capture_gate_chk.sv
// Port-level checker for the capture latch and output pin gate.
// Assumes it is bound to capture_gate_top and sees only its ports.
`timescale 1ns/1ns
module capture_gate_chk
  import cap_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Register port
  input  wire bus_req_t    bus_req,
  input  wire logic [31:0] rd_data,
  // Timer core
  input  wire logic [15:0] counter_value,
  input  wire logic [1:0]  timer_out,
  // Capture pins
  input  wire logic        port_a_pin_twelve,
  input  wire logic        port_a_pin_thirteen,
  input  wire logic [1:0]  port_a_function_select,
  input  wire logic [1:0]  cap_pin_oe,
  input  wire logic [1:0]  cap_pin_routed,
  // Output pins
  input  wire logic [1:0]  out_function_select,
  input  wire logic [1:0]  out_pin_level,
  input  wire logic [1:0]  out_pin_oe,
  // Interrupt
  input  wire logic        irq
);
  logic [1:0] pins_q;
  logic [2:0] quiet_q;
  wire  [1:0] pins_now = {port_a_pin_thirteen, port_a_pin_twelve};
  wire        pin_moved = pins_now != pins_q;

  // Cycles since a pin moved; an edge in flight can still set status for three
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pins_q  <= 2'h0;
      quiet_q <= 3'h0;
    end else begin
      pins_q  <= pins_now;
      quiet_q <= pin_moved ? 3'h0 : (quiet_q == 3'h7 ? quiet_q : quiet_q + 3'h1);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_out_needs_func: assert property ((out_pin_oe & ~out_function_select) == 2'h0)
    else $error("output enable without timer function");
  a_out_level_gate: assert property (out_pin_level == (timer_out & out_pin_oe))
    else $error("output level not gated");
  a_cap_input_only: assert property (cap_pin_oe == 2'h0)
    else $error("capture pin driven");
  a_route_needs_func: assert property ((cap_pin_routed & ~port_a_function_select) == 2'h0)
    else $error("capture routed without timer function");
  a_gate_write_acts: assert property ((bus_req.wr && bus_req.addr == OFF_OUTPUT_GATE)
    ##1 $stable(out_function_select)
    |-> out_pin_oe == ($past(bus_req.wdata[1:0]) & out_function_select))
    else $error("gate write not applied");
  a_connect_write: assert property ((bus_req.wr && bus_req.addr == OFF_CAPTURE_PIN)
    ##1 $stable(port_a_function_select)
    |-> cap_pin_routed == ($past(bus_req.wdata[1:0]) & port_a_function_select))
    else $error("connect write not applied");
  a_status_read_clr: assert property (bus_req.rd && bus_req.addr == OFF_IRQ_STATUS
    && quiet_q >= 3'h4 |=> !irq)
    else $error("irq stays after status read");
  a_irq_has_cause: assert property ($rose(irq) |-> $past(bus_req.wr) || quiet_q <= 3'h3)
    else $error("irq without pin edge");

  c_irq_rise: cover property ($rose(irq));
  c_status_read: cover property (bus_req.rd && bus_req.addr == OFF_IRQ_STATUS && irq);
  c_gate_on: cover property ($rose(out_pin_oe[1]));
endmodule

// file: tb/cap_pulse_src.sv
// Behavioural source of the two capture pin signals.
// Assumes the bench calls drive() from its own sequence.
`timescale 1ns/1ns
module cap_pulse_src (
  // Pacing clock
  input  wire logic       clk,
  // Capture pin levels
  output logic      [1:0] pins
);
  initial pins = 2'h0;

  // Hold in cycles: short gives a prompt source, long a slow one
  task automatic drive(input int ch, input logic lvl, input int hold);
    @(posedge clk);
    pins[ch] <= lvl;
    repeat (hold) @(posedge clk);
  endtask
endmodule

// file: tb/capture_gate_top_tb.sv
// Self-checking bench for the capture latch and output pin gate.
// Assumes the package, checker and pulse source are compiled first.
`timescale 1ns/1ns
module capture_gate_top_tb;
  import cap_pkg::*;
  logic        clk;
  logic        rst_b;
  bus_req_t    bus_req;
  logic [31:0] rd_data;
  logic [15:0] counter_value;
  logic [1:0]  timer_out;
  logic [1:0]  pins;
  logic [1:0]  port_a_function_select;
  logic [1:0]  out_function_select;
  logic [1:0]  cap_pin_oe;
  logic [1:0]  cap_pin_routed;
  logic [1:0]  out_pin_level;
  logic [1:0]  out_pin_oe;
  logic        irq;
  logic        rd_seen;
  logic [31:0] expq[$];
  logic [15:0] lat[4];
  logic [15:0] cv;
  logic [31:0] flags;
  logic [7:0]  offs[8] = '{OFF_RISE_LATCH_0, OFF_FALL_LATCH_0, OFF_RISE_LATCH_1,
    OFF_FALL_LATCH_1, OFF_CAPTURE_PIN, OFF_OUTPUT_GATE, OFF_IRQ_STATUS, 8'h90};
  int          n_errors;
  int          tests_run;

  capture_gate_top DUT (.clk(clk), .rst_b(rst_b), .bus_req(bus_req), .rd_data(rd_data),
    .counter_value(counter_value), .timer_out(timer_out), .port_a_pin_twelve(pins[0]),
    .port_a_pin_thirteen(pins[1]), .port_a_function_select(port_a_function_select),
    .cap_pin_oe(cap_pin_oe), .cap_pin_routed(cap_pin_routed),
    .out_function_select(out_function_select), .out_pin_level(out_pin_level),
    .out_pin_oe(out_pin_oe), .irq(irq));
  cap_pulse_src src (.clk(clk), .pins(pins));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge clk) rd_seen <= bus_req.rd;
  always @(negedge clk) begin
    if (rd_seen === 1'b1) begin
      cmp(rd_data, expq.pop_front());
    end
  end

  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    acc(1'b0, a, 32'h0);
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk);
      bus_req.wr <= 1'b0;
      bus_req.rd <= 1'b0;
    end
    @(negedge clk);
  endtask
  task automatic pin(input int ch, input logic lvl);
    idle(1);
    src.drive(ch, lvl, 5);
  endtask
  task automatic latches;
    for (int e = 0; e < 4; e++) rd(OFF_RISE_LATCH_0 + 8'(4 * e), {16'h0, lat[e]});
    rd(OFF_IRQ_STATUS, 32'h0);
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #100000;
    n_errors++;
    test_done;
  end

  initial begin
    rst_b = 1'b0;
    bus_req = '0;
    counter_value = 16'h0;
    timer_out = 2'h0;
    port_a_function_select = 2'h0;
    out_function_select = 2'h0;
    n_errors = 0;
    tests_run = 0;
    flags = 32'h0;
    void'($urandom(966));
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    foreach (offs[i]) rd(offs[i], 32'h0);
    acc(1'b1, OFF_CAPTURE_PIN, 32'hFFFF_FFFF);
    rd(OFF_CAPTURE_PIN, 32'h3);
    for (int g = 0; g < 4; g++) begin
      for (int f = 0; f < 4; f++) begin
        acc(1'b1, OFF_OUTPUT_GATE, 32'(g));
        out_function_select <= 2'(f);
        timer_out <= 2'($urandom);
        idle(1);
        cmp(32'(out_pin_oe), 32'(g & f));
        cmp(32'(out_pin_level), 32'(timer_out & g & f));
      end
    end
    rd(OFF_OUTPUT_GATE, 32'h3);
    acc(1'b1, OFF_IRQ_MASK, 32'hF);
    acc(1'b1, OFF_CAPTURE_CTRL, 32'h000E_000E);
    port_a_function_select <= 2'h3;
    for (int e = 0; e < 4; e++) begin
      cv = 16'($urandom);
      lat[e] = cv;
      // Drop the control write strobe first, so that the write lasts one cycle
      idle(1);
      @(posedge clk);
      counter_value <= cv;
      pin(e / 2, !e[0]);
      idle(1);
      cmp(32'(irq), 32'h1);
      flags |= (e[0] ? 32'h90 : 32'h50) << (16 * (e / 2));
      rd(OFF_RISE_LATCH_0 + 8'(4 * e), {16'h0, cv});
      rd(OFF_CAPTURE_CTRL, 32'h000E_000E | flags);
      rd(OFF_IRQ_STATUS, 32'h1 << e);
      idle(1);
      cmp(32'(irq), 32'h0);
    end
    // Flags clear by zero, the interrupt flag by one
    acc(1'b1, OFF_CAPTURE_CTRL, 32'h001E_001E);
    rd(OFF_CAPTURE_CTRL, 32'h000E_000E);
    acc(1'b1, OFF_CAPTURE_PIN, 32'h0);
    counter_value <= 16'($urandom);
    pin(0, 1'b1);
    pin(1, 1'b1);
    latches;
    acc(1'b1, OFF_CAPTURE_CTRL, 32'h0006_0006);
    acc(1'b1, OFF_CAPTURE_PIN, 32'h3);
    pin(0, 1'b0);
    pin(1, 1'b0);
    latches;
    idle(3);
    test_done;
  end
endmodule

bind capture_gate_top capture_gate_chk chk_i (.clk(clk), .rst_b(rst_b), .bus_req(bus_req),
  .rd_data(rd_data), .counter_value(counter_value), .timer_out(timer_out),
  .port_a_pin_twelve(port_a_pin_twelve), .port_a_pin_thirteen(port_a_pin_thirteen),
  .port_a_function_select(port_a_function_select), .cap_pin_oe(cap_pin_oe),
  .cap_pin_routed(cap_pin_routed), .out_function_select(out_function_select),
  .out_pin_level(out_pin_level), .out_pin_oe(out_pin_oe), .irq(irq));
